// ===== common/pscr_regs.svh
// Offsets, field positions, masks and reset values of the status/command register
`ifndef PSCR_REGS_SVH
`define PSCR_REGS_SVH

// ----------------------------------------------------------------------------
// Register address and width
// ----------------------------------------------------------------------------
`define PSCR_REG_ADDR          32'h8000_0104
`define PSCR_DATA_W            32

// ----------------------------------------------------------------------------
// Status half: bit positions
// ----------------------------------------------------------------------------
`define PSCR_BIT_BUS_PERR      31
`define PSCR_BIT_SERR_SIG      30
`define PSCR_BIT_MST_ABORT     29
`define PSCR_BIT_TGT_ABT_RCVD  28
`define PSCR_BIT_TGT_ABT_SIG   27
`define PSCR_SEL_TIMING_HI     26
`define PSCR_SEL_TIMING_LO     25
`define PSCR_BIT_MST_DPERR     24
`define PSCR_BIT_FAST_B2B_CAP  23
`define PSCR_BIT_SPEED_66      21
`define PSCR_BIT_CAP_LIST      20
`define PSCR_BIT_INT_STATUS    19

// ----------------------------------------------------------------------------
// Command half: bit positions
// ----------------------------------------------------------------------------
`define PSCR_BIT_INT_DISABLE   10
`define PSCR_BIT_FAST_B2B_EN   9
`define PSCR_BIT_SERR_EN       8
`define PSCR_BIT_STEPPING      7
`define PSCR_BIT_PAR_RESP      6
`define PSCR_BIT_PALETTE       5
`define PSCR_BIT_MWI_EN        4
`define PSCR_BIT_SPECIAL       3
`define PSCR_BIT_INI_EN        2
`define PSCR_BIT_MEM_EN        1
`define PSCR_BIT_IO_EN         0

// ----------------------------------------------------------------------------
// Masks and values
// ----------------------------------------------------------------------------
`define PSCR_W1C_MASK          32'hF900_0000
`define PSCR_CMD_MASK          32'h0000_0357
`define PSCR_FIXED_VALUE       32'h0280_0000
`define PSCR_RESET_VALUE       32'h0000_0000
`define PSCR_SEL_MEDIUM        2'h1
`define PSCR_BE_W              4

`endif

// ===== common/pscr_pkg.sv
// Types shared by the status/command register files
package pscr_pkg;

  typedef logic [31:0] pscr_word_type;

  typedef enum logic [1:0] {
    PSCR_WSRC_NONE,
    PSCR_WSRC_LOCAL,
    PSCR_WSRC_REMOTE
  } pscr_wsrc_type;

endpackage : pscr_pkg

// ===== design/pscr_sync.sv
// Two-flip-flop synchroniser for a vector of inputs from outside the clock domain
`timescale 1ns/1ps

module pscr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  if (WIDTH < 1) begin : g_bad_width
    $error("pscr_sync: WIDTH must be at least 1");
  end

  // First stage is read only by the second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule : pscr_sync

// ===== design/pscr_status_command.sv
// Combined PCI status and command register with local and remote access
`timescale 1ns/1ps
`include "pscr_regs.svh"

// Behaviour
// - SERR flag set whenever SERR is driven
// - Master abort sets master abort flag
// - Received target abort sets its flag
// - Signalled target abort sets its flag
// - Status flags clear only on written one
// - Select timing reads medium code
// - Master data parity flag needs parity response
// - Fast back-to-back capable bit reads one
// - Capability list bit reads zero
// - Interrupt status and disable bits reserved
// - Fast back-to-back enable stored, never used
// - SERR gated; address parity needs both
// - Parity response off: flag only, no PERR
// - Write-and-invalidate only when enabled
// - Initiator starts only when enabled
// - Memory claims only when enabled
// - I/O claims only when enabled
// - Satellite mode: command read-only locally
// - Stepping, palette, special cycle bits reserved
// - Any seen PERR sets bus parity flag
module pscr_status_command (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Local processor access
  input  wire logic        LOC_WR_I,
  input  wire logic [31:0] LOC_WDATA_I,
  output logic      [31:0] LOC_RDATA_O,
  // Strap pin: high selects satellite mode
  input  wire logic        SYS_HOST_SEL_I,
  // PCI side, inputs in the PCI clock domain; CFG_RDATA_O is registered on CLK_I
  input  wire logic        PCI_CLK_I,
  input  wire logic        CFG_WR_I,
  input  wire logic [3:0]  CFG_BE_I,
  input  wire logic [31:0] CFG_WDATA_I,
  output logic      [31:0] CFG_RDATA_O,
  input  wire logic        ADDR_PAR_ERR_I,
  input  wire logic        DATA_PAR_ERR_I,
  input  wire logic        PERR_N_I,
  input  wire logic        SYS_ERR_REQ_I,
  input  wire logic        MST_ABORT_I,
  input  wire logic        TGT_ABORT_RCVD_I,
  input  wire logic        TGT_ABORT_SIG_I,
  input  wire logic        INI_READ_I,
  input  wire logic        INI_WRITE_I,
  input  wire logic        INI_REQ_I,
  input  wire logic        MWI_REQ_I,
  input  wire logic        MEM_HIT_I,
  input  wire logic        IO_HIT_I,
  // Gates to the bus engine
  output logic             INI_START_O,
  output logic             USE_MWI_O,
  output logic             MEM_CLAIM_O,
  output logic             IO_CLAIM_O,
  output logic             FAST_B2B_GEN_O,
  output logic      [1:0]  DEVSEL_TIMING_O,
  // Open-drain error pins
  output logic             SERR_N_O,
  output logic             SERR_OE_O,
  output logic             PERR_N_O,
  output logic             PERR_OE_O
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function automatic pscr_pkg::pscr_word_type be_mask(input logic [3:0] be);
    pscr_pkg::pscr_word_type m;
    m = '0;
    for (int i = 0; i < `PSCR_BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : be_mask

  function automatic pscr_pkg::pscr_word_type w1c_bits(input pscr_pkg::pscr_word_type d);
    return d & `PSCR_W1C_MASK;
  endfunction : w1c_bits

  // --------------------------------------------------------------------------
  // Synchronisers for the PCI side and the strap
  // --------------------------------------------------------------------------
  localparam int CTRL_W = 15;

  logic [CTRL_W-1:0] ctrl_s;
  logic [35:0]       cfg_s;

  pscr_sync #(.WIDTH(CTRL_W)) u_sync_ctrl (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   ({PCI_CLK_I, SYS_HOST_SEL_I, CFG_WR_I, ADDR_PAR_ERR_I, DATA_PAR_ERR_I,
             ~PERR_N_I, SYS_ERR_REQ_I, MST_ABORT_I, TGT_ABORT_RCVD_I, TGT_ABORT_SIG_I,
             INI_READ_I, INI_WRITE_I, INI_REQ_I, MWI_REQ_I, MEM_HIT_I}),
    .q_o   (ctrl_s)
  );

  pscr_sync #(.WIDTH(36)) u_sync_cfg (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   ({CFG_BE_I, CFG_WDATA_I}),
    .q_o   (cfg_s)
  );

  logic io_hit_s;

  pscr_sync #(.WIDTH(1)) u_sync_io (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   (IO_HIT_I),
    .q_o   (io_hit_s)
  );

  wire pci_clk_s    = ctrl_s[14];
  wire satellite_s  = ctrl_s[13];
  wire cfg_wr_s     = ctrl_s[12];
  wire addr_perr_s  = ctrl_s[11];
  wire data_perr_s  = ctrl_s[10];
  wire perr_seen_s  = ctrl_s[9];
  wire sys_err_s    = ctrl_s[8];
  wire mst_abort_s  = ctrl_s[7];
  wire tabt_rcvd_s  = ctrl_s[6];
  wire tabt_sig_s   = ctrl_s[5];
  wire ini_read_s   = ctrl_s[4];
  wire ini_write_s  = ctrl_s[3];
  wire ini_req_s    = ctrl_s[2];
  wire mwi_req_s    = ctrl_s[1];
  wire mem_hit_s    = ctrl_s[0];

  // --------------------------------------------------------------------------
  // PCI clock edge detection
  // --------------------------------------------------------------------------
  logic pci_clk_d_ff;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pci_clk_d_ff <= 1'b0;
    end else begin
      pci_clk_d_ff <= pci_clk_s;
    end
  end

  wire pci_rise = pci_clk_s & ~pci_clk_d_ff;

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  pscr_pkg::pscr_word_type status_ff;
  pscr_pkg::pscr_word_type cmd_ff;
  logic                    serr_drv_ff;
  logic                    perr_drv_ff;

  wire ini_en   = cmd_ff[`PSCR_BIT_INI_EN];
  wire mem_en   = cmd_ff[`PSCR_BIT_MEM_EN];
  wire io_en    = cmd_ff[`PSCR_BIT_IO_EN];
  wire mwi_en   = cmd_ff[`PSCR_BIT_MWI_EN];
  wire serr_en  = cmd_ff[`PSCR_BIT_SERR_EN];
  wire par_resp = cmd_ff[`PSCR_BIT_PAR_RESP];

  // --------------------------------------------------------------------------
  // Write source selection
  // --------------------------------------------------------------------------
  wire cfg_take = pci_rise & cfg_wr_s;
  pscr_pkg::pscr_wsrc_type cmd_src;

  assign cmd_src = (LOC_WR_I && !satellite_s) ? pscr_pkg::PSCR_WSRC_LOCAL :
                   (cfg_take && satellite_s)  ? pscr_pkg::PSCR_WSRC_REMOTE :
                                                pscr_pkg::PSCR_WSRC_NONE;

  wire pscr_pkg::pscr_word_type cfg_bmask = be_mask(cfg_s[35:32]);
  wire pscr_pkg::pscr_word_type cfg_data  = cfg_s[31:0] & cfg_bmask;

  wire pscr_pkg::pscr_word_type cmd_mask  = `PSCR_CMD_MASK;
  wire pscr_pkg::pscr_word_type cmd_remote =
    (cmd_ff & ~(cfg_bmask & cmd_mask)) | (cfg_data & cmd_mask);

  pscr_pkg::pscr_word_type nxt_cmd;

  always_comb begin
    case (cmd_src)
      pscr_pkg::PSCR_WSRC_LOCAL:  nxt_cmd = LOC_WDATA_I & cmd_mask;
      pscr_pkg::PSCR_WSRC_REMOTE: nxt_cmd = cmd_remote;
      default:                    nxt_cmd = cmd_ff;
    endcase
  end

  // --------------------------------------------------------------------------
  // Status flag set and clear
  // --------------------------------------------------------------------------
  pscr_pkg::pscr_word_type set_vec;
  pscr_pkg::pscr_word_type clr_vec;

  always_comb begin
    set_vec = '0;
    set_vec[`PSCR_BIT_BUS_PERR]     = pci_rise & (perr_seen_s | data_perr_s);
    set_vec[`PSCR_BIT_SERR_SIG]     = serr_drv_ff;
    set_vec[`PSCR_BIT_MST_ABORT]    = pci_rise & mst_abort_s;
    set_vec[`PSCR_BIT_TGT_ABT_RCVD] = pci_rise & tabt_rcvd_s;
    set_vec[`PSCR_BIT_TGT_ABT_SIG]  = pci_rise & tabt_sig_s;
    set_vec[`PSCR_BIT_MST_DPERR]    = pci_rise & par_resp &
                                      ((ini_read_s & data_perr_s) |
                                       (ini_write_s & perr_seen_s));
  end

  assign clr_vec = (LOC_WR_I ? w1c_bits(LOC_WDATA_I) : '0) |
                   (cfg_take ? w1c_bits(cfg_data) : '0);

  // Set wins over a clear in the same cycle
  wire pscr_pkg::pscr_word_type nxt_status = (status_ff & ~clr_vec) | set_vec;

  // --------------------------------------------------------------------------
  // Error pin drive, updated at each rising PCI clock edge
  // --------------------------------------------------------------------------
  // SERR gated by enables
  wire nxt_serr_drv = pci_rise ? (serr_en & (sys_err_s | (addr_perr_s & par_resp)))
                               : serr_drv_ff;
  wire nxt_perr_drv = pci_rise ? (par_resp & data_perr_s) : perr_drv_ff;

  // --------------------------------------------------------------------------
  // Register update
  // --------------------------------------------------------------------------
  // reset clears all
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      status_ff   <= `PSCR_RESET_VALUE;
      cmd_ff      <= `PSCR_RESET_VALUE;
      serr_drv_ff <= 1'b0;
      perr_drv_ff <= 1'b0;
    end else begin
      status_ff   <= nxt_status & `PSCR_W1C_MASK;
      cmd_ff      <= nxt_cmd;
      serr_drv_ff <= nxt_serr_drv;
      perr_drv_ff <= nxt_perr_drv;
    end
  end

  // --------------------------------------------------------------------------
  // Read value
  // --------------------------------------------------------------------------
  // fixed and zero bits
  wire pscr_pkg::pscr_word_type read_val = status_ff | `PSCR_FIXED_VALUE | cmd_ff;

  pscr_pkg::pscr_word_type loc_rdata_ff;
  pscr_pkg::pscr_word_type cfg_rdata_ff;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      loc_rdata_ff <= `PSCR_FIXED_VALUE;
      cfg_rdata_ff <= `PSCR_FIXED_VALUE;
    end else begin
      loc_rdata_ff <= read_val;
      cfg_rdata_ff <= read_val;
    end
  end

  assign LOC_RDATA_O = loc_rdata_ff;
  assign CFG_RDATA_O = cfg_rdata_ff;

  // --------------------------------------------------------------------------
  // Gates to the bus engine
  // --------------------------------------------------------------------------
  logic ini_start_ff;
  logic use_mwi_ff;
  logic mem_claim_ff;
  logic io_claim_ff;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ini_start_ff <= 1'b0;
      use_mwi_ff   <= 1'b0;
      mem_claim_ff <= 1'b0;
      io_claim_ff  <= 1'b0;
    end else begin
      ini_start_ff <= ini_req_s & ini_en;
      use_mwi_ff   <= mwi_req_s & mwi_en;
      mem_claim_ff <= mem_hit_s & mem_en;
      io_claim_ff  <= io_hit_s & io_en;
    end
  end

  assign INI_START_O     = ini_start_ff;
  assign USE_MWI_O       = use_mwi_ff;
  assign MEM_CLAIM_O     = mem_claim_ff;
  assign IO_CLAIM_O      = io_claim_ff;
  assign FAST_B2B_GEN_O  = 1'b0;
  assign DEVSEL_TIMING_O = `PSCR_SEL_MEDIUM;

  // Open drain: pull low while enabled
  assign SERR_N_O  = 1'b0;
  assign SERR_OE_O = serr_drv_ff;
  assign PERR_N_O  = 1'b0;
  assign PERR_OE_O = perr_drv_ff;

endmodule : pscr_status_command

// ===== bench/pscr_checker.sv
// Port-level checks of the status/command register
`timescale 1ns/1ps

module pscr_checker (
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        LOC_WR_I,
  input wire logic [31:0] LOC_WDATA_I,
  input wire logic [31:0] LOC_RDATA_O,
  input wire logic        CFG_WR_I,
  input wire logic [3:0]  CFG_BE_I,
  input wire logic [31:0] CFG_WDATA_I,
  input wire logic        MST_ABORT_I,
  input wire logic        INI_START_O,
  input wire logic        USE_MWI_O,
  input wire logic        MEM_CLAIM_O,
  input wire logic        FAST_B2B_GEN_O,
  input wire logic [1:0]  DEVSEL_TIMING_O,
  input wire logic        SERR_OE_O,
  input wire logic        PERR_OE_O
);
  default clocking dcb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  timing_code_a:
    assert property (DEVSEL_TIMING_O == 2'h1) else $error("select timing code wrong");
  no_fast_b2b_a:
    assert property (!FAST_B2B_GEN_O) else $error("fast back-to-back generated");
  fixed_bits_a:
    assert property ((LOC_RDATA_O & 32'h06FF_FCA8) == 32'h0280_0000)
    else $error("fixed or reserved bits wrong");
  serr_flag_a:
    assert property (SERR_OE_O |-> ##[1:3] LOC_RDATA_O[30]) else $error("error flag not set");
  serr_gate_a:
    assert property ($rose(SERR_OE_O) |-> LOC_RDATA_O[8] || $past(LOC_RDATA_O[8]))
    else $error("system error driven while disabled");
  perr_gate_a:
    assert property ($rose(PERR_OE_O) |-> LOC_RDATA_O[6] || $past(LOC_RDATA_O[6]))
    else $error("parity error driven while disabled");
  ini_gate_a:
    assert property ($rose(INI_START_O) |-> LOC_RDATA_O[2] || $past(LOC_RDATA_O[2]))
    else $error("initiator started while disabled");
  mwi_gate_a:
    assert property ($rose(USE_MWI_O) |-> LOC_RDATA_O[4] || $past(LOC_RDATA_O[4]))
    else $error("invalidate used while disabled");
  mem_drop_a:
    assert property ($fell(LOC_RDATA_O[1]) |-> ##[0:2] !MEM_CLAIM_O)
    else $error("memory claim kept after disable");
  abort_flag_a:
    assert property ($rose(MST_ABORT_I) |-> ##[3:14] LOC_RDATA_O[29])
    else $error("master abort flag not set");
  w1c_hold_a:
    assert property ($fell(LOC_RDATA_O[29]) |-> $past(LOC_WR_I && LOC_WDATA_I[29], 2) ||
                     $past(CFG_WR_I && CFG_BE_I[3] && CFG_WDATA_I[29], 4))
    else $error("flag cleared without a written one");
endmodule : pscr_checker

bind pscr_status_command pscr_checker i_pscr_checker (
  .CLK_I(CLK_I), .RST_I(RST_I), .LOC_WR_I(LOC_WR_I), .LOC_WDATA_I(LOC_WDATA_I),
  .LOC_RDATA_O(LOC_RDATA_O), .CFG_WR_I(CFG_WR_I), .CFG_BE_I(CFG_BE_I),
  .CFG_WDATA_I(CFG_WDATA_I), .MST_ABORT_I(MST_ABORT_I), .INI_START_O(INI_START_O),
  .USE_MWI_O(USE_MWI_O), .MEM_CLAIM_O(MEM_CLAIM_O), .FAST_B2B_GEN_O(FAST_B2B_GEN_O),
  .DEVSEL_TIMING_O(DEVSEL_TIMING_O), .SERR_OE_O(SERR_OE_O), .PERR_OE_O(PERR_OE_O)
);

// ===== bench/pscr_pci_model.sv
// Remote host bridge: PCI clock, configuration writes and bus events
`timescale 1ns/1ps

module pscr_pci_model (
  output logic        pci_clk_o,
  output logic        cfg_wr_o,
  output logic [3:0]  cfg_be_o,
  output logic [31:0] cfg_wdata_o,
  output logic [7:0]  ev_o,
  output logic        perr_n_o
);
  initial begin
    pci_clk_o   = 1'b0;
    cfg_wr_o    = 1'b0;
    cfg_be_o    = 4'h0;
    cfg_wdata_o = 32'h5A5A_5A5A;
    ev_o        = 8'h00;
    perr_n_o    = 1'b1;
  end

  // ------
  // One PCI period; clock stands still between calls
  // ------
  // remote configuration write, bus events and PERR
  task automatic cycle(input logic wr, input logic [3:0] be, input logic [31:0] data,
                       input logic [7:0] ev, input logic perr_n);
    #3;
    cfg_wr_o    = wr;
    cfg_be_o    = be;
    cfg_wdata_o = data;
    ev_o        = ev;
    perr_n_o    = perr_n;
    #80;
    pci_clk_o   = 1'b1;
    #80;
    pci_clk_o   = 1'b0;
    cfg_wr_o    = 1'b0;
    cfg_be_o    = 4'h0;
    cfg_wdata_o = ~data;
    ev_o        = 8'h00;
    perr_n_o    = 1'b1;
    #80;
  endtask : cycle
endmodule : pscr_pci_model

// ===== bench/tb_pscr_status_command.sv
// Self-checking bench of the PCI status/command register
`timescale 1ns/1ps
`include "pscr_regs.svh"

module tb_pscr_status_command;
  logic        clk, rst, loc_wr, host_sel, pci_clk, cfg_wr, perr_n, perr_oe, fast_b2b;
  logic        serr_oe, serr_lo, perr_lo;
  logic [31:0] loc_wdata, loc_rdata, cfg_rdata, cfg_wdata;
  logic [3:0]  req, gate, cfg_be;
  logic [7:0]  ev;
  logic [1:0]  devsel;
  int          n_fail, checks, cycles;
  int          gbit[4] = '{2, 4, 1, 0};
  logic [31:0] pcmd[7] = '{32'h0, 32'h40, 32'h40, 32'h0, 32'h0, 32'h100, 32'h140};
  logic [7:0]  pev[7]  = '{8'h42, 8'h42, 8'h01, 8'h01, 8'h20, 8'h80, 8'h80};
  logic        ppn[7]  = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [31:0] pexp[7] = '{32'h8000_0000, 32'h8100_0000, 32'h8100_0000, 32'h8000_0000,
                           32'h0, 32'h0, 32'h4000_0000};

  pscr_pci_model i_pscr_pci_model (.pci_clk_o(pci_clk), .cfg_wr_o(cfg_wr), .cfg_be_o(cfg_be),
    .cfg_wdata_o(cfg_wdata), .ev_o(ev), .perr_n_o(perr_n));

  pscr_status_command i_pscr_status_command (
    .CLK_I(clk), .RST_I(rst), .LOC_WR_I(loc_wr), .LOC_WDATA_I(loc_wdata),
    .LOC_RDATA_O(loc_rdata), .SYS_HOST_SEL_I(host_sel), .PCI_CLK_I(pci_clk),
    .CFG_WR_I(cfg_wr), .CFG_BE_I(cfg_be), .CFG_WDATA_I(cfg_wdata), .CFG_RDATA_O(cfg_rdata),
    .ADDR_PAR_ERR_I(ev[7]), .DATA_PAR_ERR_I(ev[6]), .PERR_N_I(perr_n & ~perr_oe),
    .SYS_ERR_REQ_I(ev[5]), .MST_ABORT_I(ev[4]), .TGT_ABORT_RCVD_I(ev[3]),
    .TGT_ABORT_SIG_I(ev[2]), .INI_READ_I(ev[1]), .INI_WRITE_I(ev[0]), .INI_REQ_I(req[3]),
    .MWI_REQ_I(req[2]), .MEM_HIT_I(req[1]), .IO_HIT_I(req[0]), .INI_START_O(gate[3]),
    .USE_MWI_O(gate[2]), .MEM_CLAIM_O(gate[1]), .IO_CLAIM_O(gate[0]),
    .FAST_B2B_GEN_O(fast_b2b), .DEVSEL_TIMING_O(devsel), .SERR_N_O(serr_lo),
    .SERR_OE_O(serr_oe), .PERR_N_O(perr_lo), .PERR_OE_O(perr_oe));

  // ------
  // Clock, timeout and shared tasks
  // ------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [31:0] d);
    @(posedge clk);
    loc_wr    <= 1'b1;
    loc_wdata <= d;
    @(posedge clk);
    loc_wr    <= 1'b0;
    loc_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [31:0] exp);
    repeat (4) @(posedge clk);
    #1;
    cmp(loc_rdata, exp);
    cmp(cfg_rdata, exp);
  endtask : rd

  task automatic pci_ev(input logic [7:0] e, input logic pn);
    i_pscr_pci_model.cycle(1'b0, 4'h0, 32'h0, e, pn);
    i_pscr_pci_model.cycle(1'b0, 4'h0, 32'h0, 8'h00, 1'b1);
  endtask : pci_ev

  // ------
  // Main sequence
  // ------
  initial begin
    rst       = 1'b1;
    loc_wr    = 1'b0;
    loc_wdata = 32'h0;
    host_sel  = 1'b0;
    req       = 4'h0;
    n_fail    = 0;
    checks    = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`PSCR_FIXED_VALUE);
    wr(32'hFFFF_FFFF);
    rd(`PSCR_FIXED_VALUE | `PSCR_CMD_MASK);
    cmp({30'h0, devsel}, 32'h1);
    cmp({31'h0, fast_b2b}, 32'h0);
    cmp({30'h0, serr_lo, perr_lo}, 32'h0);
    req <= 4'hF;
    for (int k = 0; k < 4; k++) begin
      wr(32'h1 << gbit[k]);
      rd(`PSCR_FIXED_VALUE | (32'h1 << gbit[k]));
      cmp({28'h0, gate}, 32'h8 >> k);
    end
    wr(`PSCR_CMD_MASK);
    req <= 4'h0;
    rd(`PSCR_FIXED_VALUE | `PSCR_CMD_MASK);
    cmp({28'h0, gate}, 32'h0);
    wr(32'h140);
    for (int k = 0; k < 4; k++) begin
      pci_ev(8'h20 >> k, 1'b1);
      rd(`PSCR_FIXED_VALUE | 32'h140 | (32'h4000_0000 >> k));
      wr(32'h140);
      rd(`PSCR_FIXED_VALUE | 32'h140 | (32'h4000_0000 >> k));
      wr(32'h140 | (32'h4000_0000 >> k));
      rd(`PSCR_FIXED_VALUE | 32'h140);
    end
    for (int k = 0; k < 7; k++) begin
      wr(pcmd[k]);
      i_pscr_pci_model.cycle(1'b0, 4'h0, 32'h0, pev[k], ppn[k]);
      cmp({30'h0, serr_oe, perr_oe}, {30'h0, pexp[k][30], pcmd[k][6] & pev[k][6]});
      i_pscr_pci_model.cycle(1'b0, 4'h0, 32'h0, 8'h00, 1'b1);
      cmp({30'h0, serr_oe, perr_oe}, 32'h0);
      rd(`PSCR_FIXED_VALUE | pcmd[k] | pexp[k]);
      wr(pcmd[k] | `PSCR_W1C_MASK);
      rd(`PSCR_FIXED_VALUE | pcmd[k]);
    end
    wr(32'h0);
    host_sel <= 1'b1;
    repeat (4) @(posedge clk);
    wr(`PSCR_CMD_MASK);
    rd(`PSCR_FIXED_VALUE);
    i_pscr_pci_model.cycle(1'b1, 4'h3, 32'hFFFF_FFFF, 8'h00, 1'b1);
    rd(`PSCR_FIXED_VALUE | `PSCR_CMD_MASK);
    i_pscr_pci_model.cycle(1'b1, 4'h1, 32'h0, 8'h00, 1'b1);
    rd(`PSCR_FIXED_VALUE | 32'h300);
    host_sel <= 1'b0;
    repeat (4) @(posedge clk);
    i_pscr_pci_model.cycle(1'b1, 4'hF, 32'h0, 8'h00, 1'b1);
    rd(`PSCR_FIXED_VALUE | 32'h300);
    pci_ev(8'h10, 1'b1);
    rd(`PSCR_FIXED_VALUE | 32'h2000_0300);
    i_pscr_pci_model.cycle(1'b1, 4'h7, 32'hFFFF_FFFF, 8'h00, 1'b1);
    rd(`PSCR_FIXED_VALUE | 32'h2000_0300);
    i_pscr_pci_model.cycle(1'b1, 4'h8, 32'h2000_0000, 8'h00, 1'b1);
    rd(`PSCR_FIXED_VALUE | 32'h300);
    pci_ev(8'h10, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`PSCR_FIXED_VALUE);
    summarize();
  end
endmodule : tb_pscr_status_command
